/* File: bench/core_sleep_model.sv */
/*
 * core side model: raises the sleep level on request, drops it on wake,
 * and follows the program counter across the wake and vector sequence.
 * assumes the block under test on the same clock and reset.
 */
`timescale 1ns/1ps

module core_sleep_model (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_sleep_req,
    input wire logic i_wake,
    input wire logic i_vector_load,
    input wire logic [12:0] i_vector_addr,
    output logic o_sleep,
    output logic [7:0] o_wake_count,
    output logic [7:0] o_vector_count,
    output logic [7:0] o_gap,
    output logic [12:0] o_pc
);
    logic [7:0] since_wake_reg;

    // sleep level, wake count and cycles from wake to vector load
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sleep <= 1'b0;
            o_wake_count <= 8'h00;
            o_vector_count <= 8'h00;
            o_gap <= 8'h00;
            o_pc <= 13'h0100;
            since_wake_reg <= 8'h00;
        end else begin
            since_wake_reg <= since_wake_reg + 8'h01;
            if (i_sleep_req) begin
                o_sleep <= 1'b1;
            end
            if (i_wake) begin
                o_sleep <= 1'b0;
                o_wake_count <= o_wake_count + 8'h01;
                since_wake_reg <= 8'h00;
                o_pc <= o_pc + 13'h0001;
            end
            if (i_vector_load) begin
                o_vector_count <= o_vector_count + 8'h01;
                o_gap <= since_wake_reg;
                o_pc <= i_vector_addr;
            end
        end
    end
endmodule

/* File: bench/test_peripheral_irq_flag_logic.sv */
/*
 * self-checking bench for the interrupt flag block: register access over
 * wishbone, pin, timer and port sources, event status and sleep wake-up.
 * assumes the core model beside it and a single 100 MHz clock.
 */
`timescale 1ns/1ps

module test_peripheral_irq_flag_logic;
    logic i_clock, i_nrst, cyc, stb, we, pin, sleep, sleep_req;
    logic int_req, wake, vload, irq, ack;
    logic [7:0] adr, rd, w0, v0, wcnt, vcnt, gap;
    logic [3:0] sel, port;
    logic [31:0] wdat, rdat;
    logic [12:0] vaddr, pc;
    integer num_errors, checks_done, k;

    peripheral_irq_flag_logic dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_ack(ack), .o_wb_dat(rdat), .i_ext_irq_pin(pin), .i_upper_io_port(port),
        .i_sleep(sleep), .o_int_request(int_req), .o_wake(wake), .o_vector_load(vload),
        .o_vector_addr(vaddr), .o_irq(irq));

    core_sleep_model core (.i_clock(i_clock), .i_nrst(i_nrst), .i_sleep_req(sleep_req),
        .i_wake(wake), .i_vector_load(vload), .i_vector_addr(vaddr), .o_sleep(sleep),
        .o_wake_count(wcnt), .o_vector_count(vcnt), .o_gap(gap), .o_pc(pc));

    // free-running clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task print_verdict;
        begin
            $display("mismatches %0d of %0d checks", num_errors, checks_done);
            if (num_errors == 0 && checks_done > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask

    task check(input string name, input logic [15:0] exp, input logic [15:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        integer n;
        begin
            @(posedge i_clock);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            sel <= 4'hF;
            wdat <= {24'h000000, d};
            n = 0;
            @(posedge i_clock);
            while (ack !== 1'b1 && n < 20) begin
                @(posedge i_clock);
                n = n + 1;
            end
            rd = rdat[7:0];
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
            if (n >= 20) begin
                num_errors = num_errors + 1;
                print_verdict;
            end
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string s);
        begin
            bus(1'b0, a, 8'h00);
            check(s, {8'h00, e}, {8'h00, rd & m});
        end
    endtask

    task tick(input integer n);
        repeat (n) @(posedge i_clock);
    endtask

    task sleep_now;
        begin
            @(posedge i_clock) sleep_req <= 1'b1;
            @(posedge i_clock) sleep_req <= 1'b0;
            tick(3);
        end
    endtask

    // main sequence
    initial begin
        num_errors = 0;
        checks_done = 0;
        {i_nrst, cyc, stb, we, pin, sleep_req} = 6'h00;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h00000000;
        port = 4'h0;
        repeat (20) @(posedge i_clock);
        i_nrst <= 1'b1;
        rdc(8'h00, 8'hFF, 8'h00, "control");
        rdc(8'h04, 8'hFF, 8'hFF, "option");
        rdc(8'h14, 8'hFF, 8'h00, "mask");
        rdc(8'h18, 8'hFF, 8'h01, "wake_state");
        wr(8'h1C, 8'hFF);
        rdc(8'h1C, 8'hFF, 8'h00, "unmapped");
        check("vector_addr", 16'h0004, {3'h0, vaddr});
        // both edges under both polarities
        for (k = 0; k < 4; k++) begin
            wr(8'h04, (k < 2) ? 8'hFF : 8'hBF);
            wr(8'h00, 8'h00);
            wr(8'h10, 8'h0F);
            @(posedge i_clock) pin <= ~pin;
            tick(6);
            rdc(8'h00, 8'h02, (pin == (k < 2)) ? 8'h02 : 8'h00, "ext_flag");
            rdc(8'h10, 8'h01, (pin == (k < 2)) ? 8'h01 : 8'h00, "ext_status");
        end
        wr(8'h00, 8'h82);
        tick(3);
        check("int_req_ext_off", 16'h0000, {15'h0, int_req});
        rdc(8'h00, 8'h02, 8'h02, "flag_kept");
        wr(8'h00, 8'h92);
        tick(3);
        check("int_req_ext_on", 16'h0001, {15'h0, int_req});
        wr(8'h00, 8'h80);
        wr(8'h00, 8'h90);
        tick(3);
        check("int_req_cleared", 16'h0000, {15'h0, int_req});
        // status, mask and level interrupt
        wr(8'h04, 8'hFF);
        @(posedge i_clock) pin <= 1'b1;
        tick(6);
        check("irq_masked", 16'h0000, {15'h0, irq});
        wr(8'h14, 8'h01);
        tick(2);
        check("irq_unmasked", 16'h0001, {15'h0, irq});
        wr(8'h10, 8'h01);
        tick(2);
        check("irq_cleared", 16'h0000, {15'h0, irq});
        rdc(8'h10, 8'h01, 8'h00, "status_w1c");
        wr(8'h14, 8'h00);
        // timer roll-over
        wr(8'h08, 8'hFD);
        wr(8'h00, 8'h00);
        wr(8'h10, 8'h02);
        rdc(8'h00, 8'h04, 8'h00, "ovf_early");
        tick(20);
        rdc(8'h00, 8'h04, 8'h04, "ovf_flag");
        rdc(8'h10, 8'h02, 8'h02, "ovf_status");
        wr(8'h00, 8'hA4);
        tick(3);
        check("int_req_ovf_on", 16'h0001, {15'h0, int_req});
        wr(8'h00, 8'h84);
        tick(3);
        check("int_req_ovf_off", 16'h0000, {15'h0, int_req});
        // upper port change
        wr(8'h00, 8'h00);
        @(posedge i_clock) port <= 4'hA;
        tick(4);
        rdc(8'h00, 8'h01, 8'h01, "port_flag");
        wr(8'h00, 8'h89);
        tick(3);
        check("int_req_port_on", 16'h0001, {15'h0, int_req});
        wr(8'h00, 8'h81);
        tick(3);
        check("int_req_port_off", 16'h0000, {15'h0, int_req});
        rdc(8'h0C, 8'hFF, 8'hA0, "port_read");
        tick(6);
        wr(8'h00, 8'h00);
        tick(4);
        rdc(8'h00, 8'h01, 8'h00, "port_resync");
        // wake with enable set before sleep, vector taken
        @(posedge i_clock) pin <= 1'b0;
        tick(4);
        wr(8'h00, 8'h90);
        w0 = wcnt;
        v0 = vcnt;
        sleep_now;
        rdc(8'h18, 8'hFF, 8'h02, "asleep");
        @(posedge i_clock) pin <= 1'b1;
        tick(12);
        check("wake_count", {8'h00, w0 + 8'h01}, {8'h00, wcnt});
        check("vector_count", {8'h00, v0 + 8'h01}, {8'h00, vcnt});
        check("vector_gap", 16'h0001, {15'h0, gap >= 8'h01 && gap <= 8'h06});
        check("core_pc", 16'h0004, {3'h0, pc});
        rdc(8'h18, 8'hFF, 8'h01, "running");
        // enable set only after sleep entry must not wake
        wr(8'h00, 8'h80);
        @(posedge i_clock) pin <= 1'b0;
        tick(4);
        wr(8'h00, 8'h80);
        sleep_now;
        wr(8'h00, 8'h90);
        @(posedge i_clock) pin <= 1'b1;
        tick(12);
        check("no_wake", {8'h00, w0 + 8'h01}, {8'h00, wcnt});
        rdc(8'h18, 8'hFF, 8'h02, "still_asleep");
        // port change wakes, no vector without global enable
        wr(8'h00, 8'h18);
        @(posedge i_clock) port <= 4'h5;
        tick(12);
        check("port_wake", {8'h00, w0 + 8'h02}, {8'h00, wcnt});
        check("no_vector", {8'h00, v0 + 8'h01}, {8'h00, vcnt});
        print_verdict;
    end
endmodule

/* File: rtl/irq_flag_cfg.svh */
/*
 * constants of the interrupt flag block: register offsets, bit positions,
 * reset values and fixed figures of the instruction cycle.
 * assumes inclusion by bare name from any file that needs it.
 */
`ifndef IRQ_FLAG_CFG_SVH
`define IRQ_FLAG_CFG_SVH

// word offsets on the register bus (byte addresses)
`define OFS_IRQ_CONTROL 8'h00
`define OFS_OPTION 8'h04
`define OFS_TIMER_COUNT 8'h08
`define OFS_UPPER_IO_PORT 8'h0C
`define OFS_EVENT_STATUS 8'h10
`define OFS_EVENT_MASK 8'h14
`define OFS_WAKE_STATE 8'h18

// irq_control_reg fields
`define BIT_PORT_CHANGE_FLAG 0
`define BIT_EXT_PIN_IRQ_FLAG 1
`define BIT_TIMER_OVERFLOW_FLAG 2
`define BIT_PORT_CHANGE_ENABLE 3
`define BIT_EXT_PIN_IRQ_ENABLE 4
`define BIT_TIMER_OVERFLOW_ENABLE 5
`define BIT_GLOBAL_IRQ_ENABLE 7

// option register field
`define BIT_EDGE_POLARITY_SELECT 6

// event status and mask fields
`define EV_EXT_EDGE 0
`define EV_TIMER_OVERFLOW 1
`define EV_PORT_CHANGE 2
`define EV_WAKE 3

// reset values
`define RST_IRQ_CONTROL 8'h00
`define RST_OPTION 8'hFF
`define RST_TIMER_COUNT 8'h00
`define RST_EVENT 4'h0

// fixed figures
`define TIMER_MAX 8'hFF
`define IRQ_VECTOR_ADDR 13'h0004
`define CLKS_PER_PHASE 8'h01

`endif

/* File: rtl/irq_flag_pkg.sv */
/*
 * types shared by the interrupt flag block.
 * assumes nothing of its surroundings.
 */
package irq_flag_pkg;

    // quarter phases of the instruction cycle, one-hot
    typedef enum logic [3:0] {
        PH_Q1 = 4'h1,
        PH_Q2 = 4'h2,
        PH_Q3 = 4'h4,
        PH_Q4 = 4'h8
    } phase_e;

    // sleep and wake sequence, one-hot
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_SLEEP = 4'h2,
        ST_EXEC = 4'h4,
        ST_VECTOR = 4'h8
    } wake_state_e;

endpackage

/* File: rtl/level_edge_watch.sv */
/*
 * remembers the last value of a group of levels and reports rising and
 * falling edges per bit.
 * assumes inputs synchronous to the clock.
 */
`timescale 1ns/1ps

module level_edge_watch #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [WIDTH-1:0] i_level,
    output logic [WIDTH-1:0] o_rise,
    output logic [WIDTH-1:0] o_fall
);

    initial begin
        if (WIDTH < 1) begin
            $error("level_edge_watch: WIDTH must be at least one");
        end
    end

    logic [WIDTH-1:0] last_reg;

    // previous sample
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            last_reg <= '0;
        end else begin
            last_reg <= i_level;
        end
    end

    // edges against previous sample
    assign o_rise = i_level & ~last_reg;
    assign o_fall = ~i_level & last_reg;

endmodule

/* File: rtl/peripheral_irq_flag_logic.sv */
/*
 * interrupt flag and enable logic for three sources: external pin edge,
 * 8-bit timer overflow and change on the upper four port pins, with sleep
 * wake-up and vectoring, reached over a classic wishbone slave.
 * assumes pins synchronous to i_clock and a core that answers o_wake and
 * o_vector_load.
 */
// Notes on behaviour
// - the pin edge that counts is rising when polarity select is one, else falling.
// - a valid pin edge sets the external pin flag, bit 1 of the control register.
// - a cleared external pin enable (bit 4) keeps that source off the request.
// - a pin edge wakes from sleep only if its enable was set at sleep entry.
// - after a wake the vector is taken only with global enable set.
// - with global enable, one instruction runs after wake, then the vector 0004h loads.
// - the timer rolling from FFh to 00h sets the overflow flag, bit 2.
// - the overflow enable, bit 5, gates the timer request.
// - a level change on port pins 7..4 sets the port change flag, bit 0.
// - the port change enable, bit 3, gates the port request.
// - a change during a port read, Q2 up to Q3, may be missed.
// - the external pin flag is set only during Q4 or Q1.
`timescale 1ns/1ps
`include "irq_flag_cfg.svh"

module peripheral_irq_flag_logic #(
    parameter int ADR_WIDTH = 8
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADR_WIDTH-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    input wire logic i_ext_irq_pin,
    input wire logic [3:0] i_upper_io_port,
    input wire logic i_sleep,
    output logic o_int_request,
    output logic o_wake,
    output logic o_vector_load,
    output logic [12:0] o_vector_addr,
    output logic o_irq
);

    initial begin
        if (ADR_WIDTH < 8) begin
            $error("peripheral_irq_flag_logic: ADR_WIDTH must be at least 8");
        end
    end

    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [7:0] ctl_reg;
    logic [7:0] opt_reg;
    logic [7:0] timer_count;
    logic [3:0] port_latch_reg;
    logic read_pend_reg;
    logic pend_edge_reg;
    logic [3:0] status_reg;
    logic [3:0] mask_reg;
    logic snap_ext_en_reg;
    logic int_req_reg;
    logic wake_reg;
    logic vec_reg;
    logic irq_reg;
    irq_flag_pkg::wake_state_e state_reg;
    irq_flag_pkg::wake_state_e state_next;
    logic q1;
    logic q2;
    logic q3;
    logic q4;
    logic pin_rise;
    logic pin_fall;
    logic sleep_rise;
    logic unused_sleep_fall;

    // quarter phase enables
    quad_phase_gen u_phase (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .o_q1(q1),
        .o_q2(q2),
        .o_q3(q3),
        .o_q4(q4)
    );

    // pin and sleep edges
    level_edge_watch #(.WIDTH(2)) u_edges (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_level({i_sleep, i_ext_irq_pin}),
        .o_rise({sleep_rise, pin_rise}),
        .o_fall({unused_sleep_fall, pin_fall})
    );

    // bus decode
    wire [7:0] adr = i_wb_adr[7:0];
    wire upper_zero = (i_wb_adr >> 8) == '0;
    wire access = i_wb_cyc && i_wb_stb && !ack_reg;
    wire wr = access && i_wb_we && i_wb_sel[0] && upper_zero;
    wire rd = access && !i_wb_we && upper_zero;
    wire wr_ctl = wr && (adr == `OFS_IRQ_CONTROL);
    wire wr_opt = wr && (adr == `OFS_OPTION);
    wire wr_tmr = wr && (adr == `OFS_TIMER_COUNT);
    wire wr_stat = wr && (adr == `OFS_EVENT_STATUS);
    wire wr_mask = wr && (adr == `OFS_EVENT_MASK);
    wire rd_port = rd && (adr == `OFS_UPPER_IO_PORT);
    wire [7:0] wd = i_wb_dat[7:0];

    // read data selection, unmapped reads as zero
    wire [7:0] rmux =
        (adr == `OFS_IRQ_CONTROL) ? ctl_reg :
        (adr == `OFS_OPTION) ? opt_reg :
        (adr == `OFS_TIMER_COUNT) ? timer_count :
        (adr == `OFS_UPPER_IO_PORT) ? {i_upper_io_port, 4'h0} :
        (adr == `OFS_EVENT_STATUS) ? {4'h0, status_reg} :
        (adr == `OFS_EVENT_MASK) ? {4'h0, mask_reg} :
        (adr == `OFS_WAKE_STATE) ? {4'h0, state_reg} : 8'h00;

    // external pin edge: polarity select picks the edge, flag set in Q4/Q1
    wire polarity = opt_reg[`BIT_EDGE_POLARITY_SELECT];
    wire valid_edge = polarity ? pin_rise : pin_fall;
    wire ext_window = q4 || q1;
    wire ext_set = pend_edge_reg && ext_window;
    wire pend_next = valid_edge || (pend_edge_reg && !ext_window);

    // timer ticks once per instruction cycle, held in sleep
    wire tick = q4 && (state_reg != irq_flag_pkg::ST_SLEEP);
    wire tmr_ovf = tick && (timer_count == `TIMER_MAX);

    // port change against the latch, blind while a read lands in Q2
    wire read_window = read_pend_reg && q2;
    wire port_set = (i_upper_io_port != port_latch_reg) && !read_window;

    // flag set wins over a firmware clear
    wire [2:0] flag_set;
    assign flag_set[`BIT_PORT_CHANGE_FLAG] = port_set;
    assign flag_set[`BIT_EXT_PIN_IRQ_FLAG] = ext_set;
    assign flag_set[`BIT_TIMER_OVERFLOW_FLAG] = tmr_ovf;
    wire [2:0] flag_keep = wr_ctl ? wd[2:0] : ctl_reg[2:0];
    wire [7:0] ctl_next = wr_ctl ? {wd[7:3], flag_set | flag_keep}
                                 : {ctl_reg[7:3], flag_set | flag_keep};

    // combined request: each flag gated by its own enable
    wire port_req = ctl_reg[`BIT_PORT_CHANGE_FLAG] && ctl_reg[`BIT_PORT_CHANGE_ENABLE];
    wire ext_req = ctl_reg[`BIT_EXT_PIN_IRQ_FLAG] && ctl_reg[`BIT_EXT_PIN_IRQ_ENABLE];
    wire tmr_req = ctl_reg[`BIT_TIMER_OVERFLOW_FLAG]
                   && ctl_reg[`BIT_TIMER_OVERFLOW_ENABLE];
    wire combined = port_req || ext_req || tmr_req;
    wire global_irq_enable = ctl_reg[`BIT_GLOBAL_IRQ_ENABLE];

    // wake: pin source uses the enable captured at sleep entry
    wire ext_wake = ctl_reg[`BIT_EXT_PIN_IRQ_FLAG] && snap_ext_en_reg;
    wire wake_cond = ext_wake || port_req || tmr_req;
    wire vec_go = (state_reg == irq_flag_pkg::ST_EXEC) && q4 && global_irq_enable;

    // sleep and wake sequence
    always_comb begin
        case (state_reg)
            irq_flag_pkg::ST_RUN:
                state_next = sleep_rise ? irq_flag_pkg::ST_SLEEP : irq_flag_pkg::ST_RUN;
            irq_flag_pkg::ST_SLEEP:
                state_next = wake_cond ? irq_flag_pkg::ST_EXEC : irq_flag_pkg::ST_SLEEP;
            irq_flag_pkg::ST_EXEC: begin
                // next instruction completes at Q4, then vector or carry on
                if (q4) begin
                    state_next = global_irq_enable ? irq_flag_pkg::ST_VECTOR : irq_flag_pkg::ST_RUN;
                end else begin
                    state_next = irq_flag_pkg::ST_EXEC;
                end
            end
            default: state_next = irq_flag_pkg::ST_RUN;
        endcase
    end
    wire wake_pulse = (state_reg == irq_flag_pkg::ST_SLEEP) && wake_cond;

    // event status, set wins over write-one-to-clear
    wire [3:0] ev_set = {wake_pulse, port_set, tmr_ovf, ext_set};
    wire [3:0] status_next = ev_set | (status_reg & ~(wr_stat ? wd[3:0] : 4'h0));

    // bus slave: ack one cycle after the request, dropped the next
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= access;
            rdat_reg <= rd ? {24'h00_0000, rmux} : 32'h0000_0000;
        end
    end

    // control, option, mask and timer registers
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ctl_reg <= `RST_IRQ_CONTROL;
            opt_reg <= `RST_OPTION;
            mask_reg <= `RST_EVENT;
            status_reg <= `RST_EVENT;
            timer_count <= `RST_TIMER_COUNT;
        end else begin
            ctl_reg <= ctl_next;
            opt_reg <= wr_opt ? wd : opt_reg;
            mask_reg <= wr_mask ? wd[3:0] : mask_reg;
            status_reg <= status_next;
            timer_count <= wr_tmr ? wd : (tick ? timer_count + 8'h01 : timer_count);
        end
    end

    // pin edge pending and port read latch
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pend_edge_reg <= 1'b0;
            read_pend_reg <= 1'b0;
            port_latch_reg <= 4'h0;
        end else begin
            pend_edge_reg <= pend_next;
            read_pend_reg <= rd_port || (read_pend_reg && !q2);
            port_latch_reg <= read_window ? i_upper_io_port : port_latch_reg;
        end
    end

    // wake sequence and registered outputs
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= irq_flag_pkg::ST_RUN;
            snap_ext_en_reg <= 1'b0;
            int_req_reg <= 1'b0;
            wake_reg <= 1'b0;
            vec_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == irq_flag_pkg::ST_RUN && sleep_rise) begin
                snap_ext_en_reg <= ctl_reg[`BIT_EXT_PIN_IRQ_ENABLE];
            end
            int_req_reg <= combined && global_irq_enable;
            wake_reg <= wake_pulse;
            vec_reg <= vec_go;
            irq_reg <= |(status_next & mask_reg);
        end
    end

    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;
    assign o_int_request = int_req_reg;
    assign o_wake = wake_reg;
    assign o_vector_load = vec_reg;
    assign o_vector_addr = `IRQ_VECTOR_ADDR;
    assign o_irq = irq_reg;

    // checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    property p_rise_sets;
        polarity && pin_rise && !wr_opt |-> ##[1:5] ext_set;
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");

    property p_fall_sets;
        !polarity && pin_fall && !wr_opt |-> ##[1:5] ext_set;
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

    property p_ext_flag;
        ext_set |=> ctl_reg[`BIT_EXT_PIN_IRQ_FLAG];
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("pin flag not set");

    property p_ext_phase;
        ext_set |-> (q4 || q1);
    endproperty
    a_ext_phase: assert property (p_ext_phase) else $error("pin flag outside Q4/Q1");

    property p_gate;
        global_irq_enable && !ext_req && !port_req && !tmr_req |=> !o_int_request;
    endproperty
    a_gate: assert property (p_gate) else $error("request without enabled flag");

    property p_ovf;
        tmr_ovf && !wr_tmr |=> timer_count == 8'h00 && ctl_reg[`BIT_TIMER_OVERFLOW_FLAG];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag missing");

    property p_port;
        (i_upper_io_port != port_latch_reg) && !read_window |=> ctl_reg[`BIT_PORT_CHANGE_FLAG];
    endproperty
    a_port: assert property (p_port) else $error("port change flag missing");

    property p_read_latch;
        read_window |=> port_latch_reg == $past(i_upper_io_port);
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("port latch not taken");

    property p_wake_ext;
        state_reg == irq_flag_pkg::ST_SLEEP && ext_wake
            |=> state_reg == irq_flag_pkg::ST_EXEC ##0 o_wake;
    endproperty
    a_wake_ext: assert property (p_wake_ext) else $error("no wake on pin");

    property p_vector;
        state_reg == irq_flag_pkg::ST_EXEC && q4 && global_irq_enable |=> o_vector_load ##1 !o_vector_load;
    endproperty
    a_vector: assert property (p_vector) else $error("vector not loaded");

    property p_no_vector;
        state_reg == irq_flag_pkg::ST_EXEC && q4 && !global_irq_enable
            |=> !o_vector_load && state_reg == irq_flag_pkg::ST_RUN;
    endproperty
    a_no_vector: assert property (p_no_vector) else $error("vector without enable");

    property p_ext_gate;
        !ctl_reg[`BIT_EXT_PIN_IRQ_ENABLE] && !port_req && !tmr_req |=> !o_int_request;
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("pin request while disabled");

    property p_tmr_gate;
        tmr_req && global_irq_enable |=> o_int_request;
    endproperty
    a_tmr_gate: assert property (p_tmr_gate) else $error("timer request lost");

    property p_port_gate;
        port_req && global_irq_enable |=> o_int_request;
    endproperty
    a_port_gate: assert property (p_port_gate) else $error("port request lost");

    property p_flag_hold;
        ctl_reg[`BIT_EXT_PIN_IRQ_FLAG] && !wr_ctl |=> ctl_reg[`BIT_EXT_PIN_IRQ_FLAG];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("pin flag dropped");

    property p_wake_snap;
        state_reg == irq_flag_pkg::ST_SLEEP && !snap_ext_en_reg && !port_req && !tmr_req
            |=> state_reg == irq_flag_pkg::ST_SLEEP;
    endproperty
    a_wake_snap: assert property (p_wake_snap) else $error("wake without enable");

    c_ext: cover property (ext_set);
    c_no_vector: cover property (state_reg == irq_flag_pkg::ST_EXEC && q4 && !global_irq_enable);
    c_port_read: cover property (read_window && i_upper_io_port != port_latch_reg);
    c_vector: cover property (o_vector_load);

endmodule

/* File: rtl/quad_phase_gen.sv */
/*
 * divider that walks the four quarter phases of the instruction cycle and
 * gives one enable per phase.
 * assumes a single free-running clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`include "irq_flag_cfg.svh"

module quad_phase_gen #(
    parameter logic [7:0] CLKS_PER_PHASE = `CLKS_PER_PHASE
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    output logic o_q1,
    output logic o_q2,
    output logic o_q3,
    output logic o_q4
);

    initial begin
        if (CLKS_PER_PHASE == 8'h00) begin
            $error("quad_phase_gen: CLKS_PER_PHASE must be at least one");
        end
    end

    irq_flag_pkg::phase_e phase_reg;
    irq_flag_pkg::phase_e phase_next;
    logic [7:0] div_reg;
    wire step = (div_reg == CLKS_PER_PHASE - 8'h01);

    // rotate to the following quarter
    always_comb begin
        case (phase_reg)
            irq_flag_pkg::PH_Q1: phase_next = irq_flag_pkg::PH_Q2;
            irq_flag_pkg::PH_Q2: phase_next = irq_flag_pkg::PH_Q3;
            irq_flag_pkg::PH_Q3: phase_next = irq_flag_pkg::PH_Q4;
            default: phase_next = irq_flag_pkg::PH_Q1;
        endcase
    end

    // divider and phase register
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            div_reg <= 8'h00;
            phase_reg <= irq_flag_pkg::PH_Q1;
        end else begin
            div_reg <= step ? 8'h00 : div_reg + 8'h01;
            if (step) begin
                phase_reg <= phase_next;
            end
        end
    end

    // enables last one clock each
    assign o_q1 = step && (phase_reg == irq_flag_pkg::PH_Q1);
    assign o_q2 = step && (phase_reg == irq_flag_pkg::PH_Q2);
    assign o_q3 = step && (phase_reg == irq_flag_pkg::PH_Q3);
    assign o_q4 = step && (phase_reg == irq_flag_pkg::PH_Q4);

endmodule
